// ==== dv/gpc_pin_model.sv ====
// Purpose: Pin-side partner for the third general-purpose port.
// Assumes: Every pin has a weak pull-up; external drivers are strong.
// Notes: A strong external driver wins over the port's own drive.
`timescale 1ns/1ps
module gpc_pin_model (
    // Bench side
    input wire logic [7:0] ext_drive,
    input wire logic [7:0] ext_en,
    // Port side
    input wire logic [7:0] dut_out,
    input wire logic [7:0] dut_oe,
    output logic [7:0] pin_level
);
    // ==========================================================
    // Wire resolution
    // Undriven pins float to the pull-up level, not to the last value.
    genvar i;
    for (i = 0; i < 8; i++) begin : g_pin
        assign pin_level[i] = ext_en[i] ? ext_drive[i] : (dut_oe[i] ? dut_out[i] : 1'b1);
    end
endmodule

// ==== dv/gpc_port_tb.sv ====
// Purpose: Self-checking bench for the third general-purpose port.
// Assumes: Latencies as handed over: one cycle to read back, two to the pins.
// Notes: Edge detectors answer three edges after the pin changes.
`timescale 1ns/1ps
`define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin fail_count++; \
    $display("mismatch at %0t: got %0h expected %0h", $time, (got), (exp)); end end
module gpc_port_tb;
    // ==========================================================
    // Signals
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic port_wr = 1'b0;
    logic [31:0] port_wdata = 32'h0;
    logic [31:0] port_rdata;
    logic [7:0] gp_pin_in;
    logic [7:0] gp_pin_out;
    logic [7:0] gp_pin_oe;
    gpc_pkg::gpc_ser_ctl_s ser_a_ctl = 5'h00;
    gpc_pkg::gpc_ser_ctl_s ser_b_ctl = 5'h00;
    logic ser_a_tx_clock_source = 1'b0;
    logic ser_b_tx_clock_source = 1'b0;
    gpc_pkg::gpc_ser_in_s ser_a_in;
    gpc_pkg::gpc_ser_in_s ser_b_in;
    logic irq_pending = 1'b0;
    logic soft_reset = 1'b0;
    logic host_reset = 1'b0;
    logic [3:0] pin3_irq_source;
    logic [7:0] ext_drive = 8'hFF;
    logic [7:0] ext_en = 8'h00;
    int fail_count = 0;
    int n_checks = 0;
    logic [4:0] ctl_tab [7] = '{5'h18, 5'h10, 5'h06, 5'h04, 5'h01, 5'h00, 5'h17};
    logic pin_tab [7] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0};

    always #50 ref_clk = ~ref_clk;

    gpc_port gpc_port_inst (
        .ref_clk(ref_clk), .rst_n(rst_n), .port_wr(port_wr), .port_wdata(port_wdata),
        .port_rdata(port_rdata), .gp_pin_in(gp_pin_in), .gp_pin_out(gp_pin_out),
        .gp_pin_oe(gp_pin_oe), .ser_a_ctl(ser_a_ctl), .ser_b_ctl(ser_b_ctl),
        .ser_a_tx_clock_source(ser_a_tx_clock_source), .ser_b_tx_clock_source(ser_b_tx_clock_source),
        .ser_a_in(ser_a_in), .ser_b_in(ser_b_in), .irq_pending(irq_pending),
        .soft_reset(soft_reset), .host_reset(host_reset), .pin3_irq_source(pin3_irq_source)
    );

    gpc_pin_model gpc_pin_model_inst (
        .ext_drive(ext_drive), .ext_en(ext_en), .dut_out(gp_pin_out),
        .dut_oe(gp_pin_oe), .pin_level(gp_pin_in)
    );

    // ==========================================================
    // Access tasks
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask

    // Issues one write strobe; returns one edge later with the word visible.
    task automatic port_write(input logic [31:0] word);
        port_wr = 1'b1;
        port_wdata = word;
        tick(1);
        port_wr = 1'b0;
    endtask

    task automatic end_test(input string name);
        $display("test %s done, checks %0d, mismatches %0d", name, n_checks, fail_count);
    endtask

    task automatic finish_test();
        $display("checks %0d, mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // ==========================================================
    // Watchdog
    initial begin
        #2000000;
        fail_count++;
        finish_test();
    end

    // ==========================================================
    // Main sequence
    initial begin
        tick(4);
        `CHK(port_rdata, 32'h0000_0000)
        `CHK(gp_pin_oe, 8'h00)
        `CHK(ser_a_in, 3'h4)
        rst_n = 1'b1;
        end_test("reset");
        // Data is masked by the old direction, so the pins become outputs first.
        port_write(32'h00FF_0000);
        tick(1);
        port_write(32'h00FF_00A5);
        `CHK(port_rdata, 32'h00FF_00A5)
        tick(1);
        `CHK(gp_pin_out, 8'hA5)
        `CHK(gp_pin_oe, 8'hFF)
        end_test("gpio_out");
        ext_en = 8'hFF;
        ext_drive = 8'h3C;
        port_write(32'h0000_0000);
        tick(3);
        `CHK(port_rdata, 32'h0000_003C)
        `CHK(gp_pin_oe, 8'h00)
        end_test("gpio_in");
        ext_en = 8'h00;
        port_write(32'h00FF_005A);
        tick(1);
        `CHK(port_rdata[7:0], 8'h00)
        `CHK(gp_pin_out, 8'h00)
        end_test("ignored_data");
        port_write(32'hF0F0_0000);
        for (int i = 0; i < 7; i++) begin
            ser_a_ctl = ctl_tab[i];
            ser_b_ctl = ctl_tab[i];
            tick(3);
            `CHK(gp_pin_out[7], pin_tab[i])
            `CHK(gp_pin_out[5], pin_tab[i])
        end
        for (int i = 0; i < 8; i++) begin
            {irq_pending, soft_reset, host_reset} = i[2:0];
            tick(3);
            `CHK(gp_pin_out[6], ~i[2])
            `CHK(gp_pin_out[4], ~(i[1] | i[0]))
        end
        end_test("special_out");
        ser_a_tx_clock_source = 1'b1;
        ser_b_tx_clock_source = 1'b1;
        ext_en = 8'hF0;
        port_write(32'hF000_0000);
        for (int i = 0; i < 4; i++) begin
            ext_drive[7:4] = {i[0], i[1], i[1], i[0]};
            tick(4);
            `CHK(ser_a_in, {i[0], i[0], ~i[1]})
            `CHK(ser_b_in, {i[1], i[1], ~i[0]})
        end
        ser_a_tx_clock_source = 1'b0;
        ser_b_tx_clock_source = 1'b0;
        tick(3);
        `CHK(ser_a_in, 3'h4)
        `CHK(ser_b_in, 3'h4)
        end_test("special_in");
        ext_en = 8'h0F;
        ext_drive = 8'h0F;
        port_write(32'h0F00_0000);
        tick(5);
        `CHK(pin3_irq_source, 4'h0)
        ext_drive[3] = 1'b0;
        tick(4);
        `CHK(pin3_irq_source, 4'h8)
        `CHK(port_rdata[3:0], 4'h8)
        tick(6);
        port_write(32'h0F00_0008);
        `CHK(port_rdata[3:0], 4'h0)
        tick(6);
        `CHK(pin3_irq_source, 4'h0)
        ext_drive[3:0] = 4'h0;
        tick(5);
        `CHK(pin3_irq_source, 4'h7)
        port_write(32'h0F0F_000F);
        tick(6);
        `CHK(pin3_irq_source, 4'h0)
        ext_drive[3:0] = 4'hF;
        tick(5);
        `CHK(pin3_irq_source, 4'hF)
        `CHK(port_rdata[3:0], 4'hF)
        port_write(32'h0F0F_000F);
        `CHK(port_rdata[3:0], 4'h0)
        end_test("edge_detect");
        finish_test();
    end
endmodule

// ==== pkg/gpc_pkg.sv ====
// Purpose: Shared constants and carriers for the third general-purpose port.
// Assumes: Single clock, no register bus; the port word arrives as plain ports.
// Notes: Field positions follow the 32-bit port word layout.
package gpc_pkg;

    // ==========================================================
    // Port word layout
    localparam int SEL_MSB = 31;
    localparam int SEL_LSB = 24;
    localparam int DIR_MSB = 23;
    localparam int DIR_LSB = 16;
    localparam int DAT_MSB = 7;
    localparam int DAT_LSB = 0;
    localparam int NUM_PINS = 8;
    localparam int NUM_EDGE = 4;

    // ==========================================================
    // Pin numbers with special functions
    localparam int PIN_CLK_A = 7;
    localparam int PIN_IRQ = 6;
    localparam int PIN_CLK_B = 5;
    localparam int PIN_RST = 4;

    // ==========================================================
    // Reset values
    localparam logic [7:0] SEL_RST = 8'h00;
    localparam logic [7:0] DIR_RST = 8'h00;
    localparam logic [7:0] DAT_RST = 8'h00;
    localparam logic [3:0] PEND_RST = 4'h0;

    // Per-pin mode.
    typedef enum logic [3:0] {
        GPC_GP_IN  = 4'h1,
        GPC_GP_OUT = 4'h2,
        GPC_SF_IN  = 4'h4,
        GPC_SF_OUT = 4'h8
    } gpc_mode_e;

    // Serial channel controls for one channel.
    typedef struct packed {
        logic spi_master;
        logic spi_master_clk;
        logic tx_clock_export;
        logic tx_clock;
        logic general_output_two;
    } gpc_ser_ctl_s;

    // Serial channel inputs produced for one channel.
    typedef struct packed {
        logic spi_slave_en_n;
        logic ext_tx_clock;
        logic ring_indicator;
    } gpc_ser_in_s;

    // Decodes select and direction into a one-hot mode.
    function automatic gpc_mode_e pin_mode(input logic sel, input logic dir);
        case ({sel, dir})
            2'b00: pin_mode = GPC_GP_IN;
            2'b01: pin_mode = GPC_GP_OUT;
            2'b10: pin_mode = GPC_SF_IN;
            default: pin_mode = GPC_SF_OUT;
        endcase
    endfunction

endpackage

// ==== rtl/gpc_edge_det.sv ====
// Purpose: Synchronised edge detector with a latched pending flag for one low pin.
// Assumes: Pin is synchronous in timing but is still passed through two stages.
// Notes: A new edge wins over an acknowledge in the same cycle.
`timescale 1ns/1ps
module gpc_edge_det (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Pin and control
    input wire logic pin_in,
    input wire logic enable,
    input wire logic rising,
    input wire logic ack,
    // Status
    output logic level,
    output logic pending
);
    logic sync1_ff;
    logic sync2_ff;
    logic prev_ff;
    logic pend_ff;
    logic edge_hit;
    logic nxt_pend;
    logic [2:0] fill_ff;

    // ==========================================================
    // Synchroniser and edge decode
    // Edges are ignored until the history flops hold real pin samples, so leaving reset cannot fake an edge.
    assign edge_hit = enable & fill_ff[2] & (rising ? (sync2_ff & ~prev_ff) : (~sync2_ff & prev_ff));
    assign nxt_pend = edge_hit | (pend_ff & ~ack);

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            sync1_ff <= 1'b0;
            sync2_ff <= 1'b0;
            prev_ff <= 1'b0;
            pend_ff <= 1'b0;
            fill_ff <= 3'h0;
        end else begin
            fill_ff <= {fill_ff[1:0], 1'b1};
            sync1_ff <= pin_in;
            sync2_ff <= sync1_ff;
            prev_ff <= sync2_ff;
            pend_ff <= nxt_pend;
        end
    end

    assign level = sync2_ff;
    assign pending = pend_ff;

    // ==========================================================
    // Checks
    property p_edge_sets;
        @(posedge ref_clk) disable iff (!rst_n) edge_hit |=> pend_ff;
    endproperty
    a_edge_sets: assert property (p_edge_sets) else $error("edge did not set pending");

    property p_ack_clears;
        @(posedge ref_clk) disable iff (!rst_n) (ack && !edge_hit) |=> !pend_ff;
    endproperty
    a_ack_clears: assert property (p_ack_clears) else $error("ack did not clear pending");

    property p_no_level_retrigger;
        @(posedge ref_clk) disable iff (!rst_n) (!pend_ff && $stable(sync2_ff) && $stable(prev_ff) && sync2_ff == prev_ff)
            |=> !pend_ff;
    endproperty
    a_no_level_retrigger: assert property (p_no_level_retrigger) else $error("pending set on level");

    property p_rise_only;
        @(posedge ref_clk) disable iff (!rst_n) (enable && rising && !pend_ff && prev_ff && !sync2_ff) |=> !pend_ff;
    endproperty
    a_rise_only: assert property (p_rise_only) else $error("falling edge caught in rising mode");
endmodule

// ==== rtl/gpc_port.sv ====
// Purpose: Third general-purpose port with per-pin function and direction select.
// Assumes: Port word written as plain ports; a one-cycle write strobe loads it.
// Notes: Pins are split into input, output and output enable.
// Operation
// - Select 0 means GPIO; direction picks in/out.
// - GPIO input reads the sampled pin level.
// - GPIO output drives stored data; reads back it.
// - Select 1: special input or special output.
// - Pin 7 out: SPI clock, tx clock, output two.
// - Output two is inverted onto pins 7, 5.
// - Pin 7 in: slave enable A, tx clock A.
// - Pin 5 out: SPI clock, tx clock, output two.
// - Pin 5 in: slave enable B, tx clock B.
// - Pin 6 out: active-low interrupt request mirror.
// - Pin 6 in: inverted ring indicator A.
// - Pin 4 out: active-low reset indicator.
// - Pin 4 in: inverted ring indicator B.
// - Pin 3 special input catches falling edges.
// - Pending pin 3 edge reads as data bit 3.
// - Writing 1 to data bit 3 acknowledges.
// - Only a new edge raises a new interrupt.
// - Direction 1 makes the detector catch rising edges.
// - Select 31:24, direction 23:16, data 7:0.
// - Data writes ignored unless GPIO output, except acks.
// - Pins 2..0 are identical edge detectors.
`timescale 1ns/1ps
module gpc_port (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Port word access
    input wire logic port_wr,
    input wire logic [31:0] port_wdata,
    output logic [31:0] port_rdata,
    // External pins
    input wire logic [7:0] gp_pin_in,
    output logic [7:0] gp_pin_out,
    output logic [7:0] gp_pin_oe,
    // Serial channel A and B controls
    input wire gpc_pkg::gpc_ser_ctl_s ser_a_ctl,
    input wire gpc_pkg::gpc_ser_ctl_s ser_b_ctl,
    input wire logic ser_a_tx_clock_source,
    input wire logic ser_b_tx_clock_source,
    // Serial channel A and B inputs
    output gpc_pkg::gpc_ser_in_s ser_a_in,
    output gpc_pkg::gpc_ser_in_s ser_b_in,
    // System signals
    input wire logic irq_pending,
    input wire logic soft_reset,
    input wire logic host_reset,
    // Interrupt sources to the controller
    output logic [3:0] pin3_irq_source
);
    logic [7:0] sel_ff;
    logic [7:0] dir_ff;
    logic [7:0] dat_ff;
    logic [7:0] sync1_ff;
    logic [7:0] sync2_ff;
    logic [7:0] out_ff;
    logic [7:0] oe_ff;
    logic [7:0] nxt_out;
    logic [7:0] nxt_oe;
    logic [7:0] nxt_dat;
    logic [7:0] gp_out_mask;
    logic [7:0] sf_out;
    logic [3:0] edge_pend;
    logic [3:0] ack_bits;
    logic [7:0] rd_data;
    logic clk_a_out;
    logic clk_b_out;
    gpc_pkg::gpc_ser_in_s nxt_a_in;
    gpc_pkg::gpc_ser_in_s nxt_b_in;
    gpc_pkg::gpc_ser_in_s a_in_ff;
    gpc_pkg::gpc_ser_in_s b_in_ff;

    // ==========================================================
    // Mode decode
    genvar g;
    generate
        for (g = 0; g < gpc_pkg::NUM_PINS; g++) begin : g_mode
            assign gp_out_mask[g] = (gpc_pkg::pin_mode(sel_ff[g], dir_ff[g]) == gpc_pkg::GPC_GP_OUT);
            assign nxt_oe[g] = dir_ff[g];
        end
    endgenerate

    // ==========================================================
    // Data register writes
    assign ack_bits = (port_wr ? port_wdata[3:0] : 4'h0) & sel_ff[3:0];
    assign nxt_dat = port_wr
        ? ((port_wdata[gpc_pkg::DAT_MSB:gpc_pkg::DAT_LSB] & gp_out_mask) | (dat_ff & ~gp_out_mask))
        : dat_ff;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            sel_ff <= gpc_pkg::SEL_RST;
            dir_ff <= gpc_pkg::DIR_RST;
            dat_ff <= gpc_pkg::DAT_RST;
        end else begin
            if (port_wr) begin
                sel_ff <= port_wdata[gpc_pkg::SEL_MSB:gpc_pkg::SEL_LSB];
                dir_ff <= port_wdata[gpc_pkg::DIR_MSB:gpc_pkg::DIR_LSB];
            end
            dat_ff <= nxt_dat;
        end
    end

    // ==========================================================
    // Input synchroniser
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            sync1_ff <= 8'h00;
            sync2_ff <= 8'h00;
        end else begin
            sync1_ff <= gp_pin_in;
            sync2_ff <= sync1_ff;
        end
    end

    // ==========================================================
    // Edge detectors on pins 3..0
    generate
        for (g = 0; g < gpc_pkg::NUM_EDGE; g++) begin : g_edge
            gpc_edge_det u_edge (
                .ref_clk(ref_clk),
                .rst_n(rst_n),
                .pin_in(gp_pin_in[g]),
                .enable(sel_ff[g]),
                .rising(dir_ff[g]),
                .ack(ack_bits[g]),
                .level(),
                .pending(edge_pend[g])
            );
        end
    endgenerate

    assign pin3_irq_source = edge_pend;

    // ==========================================================
    // Special-function outputs
    assign clk_a_out = ser_a_ctl.spi_master ? ser_a_ctl.spi_master_clk
        : (ser_a_ctl.tx_clock_export ? ser_a_ctl.tx_clock : ~ser_a_ctl.general_output_two);
    assign clk_b_out = ser_b_ctl.spi_master ? ser_b_ctl.spi_master_clk
        : (ser_b_ctl.tx_clock_export ? ser_b_ctl.tx_clock : ~ser_b_ctl.general_output_two);

    assign sf_out = {clk_a_out, ~irq_pending, clk_b_out, ~(soft_reset | host_reset), 4'h0};
    assign nxt_out = (sel_ff & sf_out) | (~sel_ff & dat_ff);

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            out_ff <= 8'h00;
            oe_ff <= 8'h00;
        end else begin
            out_ff <= nxt_out;
            oe_ff <= nxt_oe;
        end
    end

    assign gp_pin_out = out_ff;
    assign gp_pin_oe = oe_ff;

    // ==========================================================
    // Special-function inputs to the serial channels
    always_comb begin
        nxt_a_in.spi_slave_en_n = 1'b1;
        nxt_a_in.ext_tx_clock = 1'b0;
        nxt_a_in.ring_indicator = 1'b0;
        nxt_b_in.spi_slave_en_n = 1'b1;
        nxt_b_in.ext_tx_clock = 1'b0;
        nxt_b_in.ring_indicator = 1'b0;
        if (sel_ff[gpc_pkg::PIN_CLK_A] && !dir_ff[gpc_pkg::PIN_CLK_A]) begin
            nxt_a_in.spi_slave_en_n = sync2_ff[gpc_pkg::PIN_CLK_A];
            nxt_a_in.ext_tx_clock = ser_a_tx_clock_source & sync2_ff[gpc_pkg::PIN_CLK_A];
        end
        if (sel_ff[gpc_pkg::PIN_IRQ] && !dir_ff[gpc_pkg::PIN_IRQ]) begin
            nxt_a_in.ring_indicator = ~sync2_ff[gpc_pkg::PIN_IRQ];
        end
        if (sel_ff[gpc_pkg::PIN_CLK_B] && !dir_ff[gpc_pkg::PIN_CLK_B]) begin
            nxt_b_in.spi_slave_en_n = sync2_ff[gpc_pkg::PIN_CLK_B];
            nxt_b_in.ext_tx_clock = ser_b_tx_clock_source & sync2_ff[gpc_pkg::PIN_CLK_B];
        end
        if (sel_ff[gpc_pkg::PIN_RST] && !dir_ff[gpc_pkg::PIN_RST]) begin
            nxt_b_in.ring_indicator = ~sync2_ff[gpc_pkg::PIN_RST];
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            a_in_ff <= 3'h4;
            b_in_ff <= 3'h4;
        end else begin
            a_in_ff <= nxt_a_in;
            b_in_ff <= nxt_b_in;
        end
    end

    assign ser_a_in = a_in_ff;
    assign ser_b_in = b_in_ff;

    // ==========================================================
    // Read-back word
    generate
        for (g = 0; g < gpc_pkg::NUM_PINS; g++) begin : g_rd
            if (g < gpc_pkg::NUM_EDGE) begin : g_low
                assign rd_data[g] = sel_ff[g] ? edge_pend[g] : (dir_ff[g] ? dat_ff[g] : sync2_ff[g]);
            end else begin : g_high
                assign rd_data[g] = (dir_ff[g] & ~sel_ff[g]) ? dat_ff[g] : sync2_ff[g];
            end
        end
    endgenerate

    assign port_rdata = {sel_ff, dir_ff, 8'h00, rd_data};

    // ==========================================================
    // Checks
    property p_gp_out_drive;
        @(posedge ref_clk) disable iff (!rst_n) (!sel_ff[0] && dir_ff[0]) |=> (gp_pin_oe[0] && gp_pin_out[0] == $past(dat_ff[0]));
    endproperty
    a_gp_out_drive: assert property (p_gp_out_drive) else $error("gpio output not driven from data");

    property p_gp_in_read;
        @(posedge ref_clk) disable iff (!rst_n) (!sel_ff[5] && !dir_ff[5])
            |-> (port_rdata[5] == sync2_ff[5]) ##1 !gp_pin_oe[5];
    endproperty
    a_gp_in_read: assert property (p_gp_in_read) else $error("gpio input read wrong");

    property p_ignore_write;
        @(posedge ref_clk) disable iff (!rst_n) (port_wr && !gp_out_mask[6]) |=> dat_ff[6] == $past(dat_ff[6]);
    endproperty
    a_ignore_write: assert property (p_ignore_write) else $error("data write not ignored");

    property p_irq_pin;
        @(posedge ref_clk) disable iff (!rst_n) (sel_ff[6] && dir_ff[6] && $stable(sel_ff[6]) && $stable(dir_ff[6]))
            |=> gp_pin_out[6] == !$past(irq_pending);
    endproperty
    a_irq_pin: assert property (p_irq_pin) else $error("interrupt pin not active low");

    property p_rst_pin;
        @(posedge ref_clk) disable iff (!rst_n) (sel_ff[4] && (soft_reset || host_reset)) |=> !gp_pin_out[4];
    endproperty
    a_rst_pin: assert property (p_rst_pin) else $error("reset indicator not low");

    property p_pend_read;
        @(posedge ref_clk) disable iff (!rst_n) sel_ff[3] |-> port_rdata[3] == edge_pend[3];
    endproperty
    a_pend_read: assert property (p_pend_read) else $error("pending not reported");

    property p_ring_inv;
        @(posedge ref_clk) disable iff (!rst_n) (sel_ff[6] && !dir_ff[6]) |=> ser_a_in.ring_indicator == !$past(sync2_ff[6]);
    endproperty
    a_ring_inv: assert property (p_ring_inv) else $error("ring indicator not inverted");

    property p_clk_a_general_output_two;
        @(posedge ref_clk) disable iff (!rst_n) (sel_ff[7] && !ser_a_ctl.spi_master && !ser_a_ctl.tx_clock_export)
            |=> gp_pin_out[7] == !$past(ser_a_ctl.general_output_two);
    endproperty
    a_clk_a_general_output_two: assert property (p_clk_a_general_output_two) else $error("output two not inverted on pin 7");
endmodule
